// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import pcm_pkg::*;
;
  // --------------------
  // Stimulus and clock
  // --------------------
  logic mclk = 0, sys_rst = 1, spr_wr = 0, spr_rd = 0, supervisor = 1, count_enable = 0, cnt2_int_control = 0;
  logic ext_irq_enable = 0, load_miss_pending = 0, dcache_fill = 0, itlb_miss = 0, reserve_obtained = 0;
  logic mfspr_dispatched = 0, icbi_seen = 0, flush_op = 0, bu_result = 0, siu_result = 0, ciu_result = 0;
  logic bu_dispatch = 0, siu_dispatch = 0, ciu_dispatch = 0, snoop_hit = 0, threshold_event = 0, tb_run = 0;
  logic [9:0] spr_num = '0;
  logic [31:0] spr_wdata = '0, threshold_inst_ea = '0, threshold_data_ea = '0, last_completed_ea = '0;
  logic [31:0] current_data_ea = '0, spr_rdata, monitor_control_word, event_counter_two, q;
  logic [63:0] timebase = '0;
  logic [1:0] timebase_bit_select = '0, branch_completed_code = '0;
  logic [2:0] completed_count = '0, dispatched_count = '0, loads_completed = '0;
  logic spr_ack, perf_monitor_irq, irq_take;
  int error_cnt = 0, total_checks = 0, cyc = 0, tap = 0;
  // Code, event value, expected increment per cycle
  localparam logic [5:0] EVC [0:22] = '{6'h00, 6'h01, 6'h02, 6'h02, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h08,
    6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14};
  localparam logic [2:0] EVV [0:22] = '{3'h1, 3'h1, 3'h4, 3'h5, 3'h3, 3'h1, 3'h1, 3'h1, 3'h3, 3'h2, 3'h1, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h1, 3'h1};
  localparam int EVI [0:22] = '{0, 1, 4, 0, 3, 1, 1, 1, 2, 1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 4, 1, 1};
  localparam int TAPS [0:3] = '{16, 12, 8, 0};

  // Clock; timebase flips only the tapped bit so a wrong tap counts nothing
  always #12.5 mclk = ~mclk;
  always @(negedge mclk) begin
    if (tb_run) timebase <= timebase ^ (64'h1 << tap);
  end

  pcm_counter_two pcm_counter_two_i (.mclk(mclk), .sys_rst(sys_rst), .spr_wr(spr_wr), .spr_rd(spr_rd),
    .supervisor(supervisor), .spr_num(spr_num), .spr_wdata(spr_wdata), .count_enable(count_enable),
    .cnt2_int_control(cnt2_int_control), .ext_irq_enable(ext_irq_enable), .timebase(timebase),
    .timebase_bit_select(timebase_bit_select), .completed_count(completed_count),
    .dispatched_count(dispatched_count), .load_miss_pending(load_miss_pending), .dcache_fill(dcache_fill),
    .itlb_miss(itlb_miss), .branch_completed_code(branch_completed_code), .reserve_obtained(reserve_obtained),
    .mfspr_dispatched(mfspr_dispatched), .icbi_seen(icbi_seen), .flush_op(flush_op), .bu_result(bu_result),
    .siu_result(siu_result), .ciu_result(ciu_result), .bu_dispatch(bu_dispatch), .siu_dispatch(siu_dispatch),
    .ciu_dispatch(ciu_dispatch), .loads_completed(loads_completed), .snoop_hit(snoop_hit),
    .threshold_event(threshold_event), .threshold_inst_ea(threshold_inst_ea),
    .threshold_data_ea(threshold_data_ea), .last_completed_ea(last_completed_ea),
    .current_data_ea(current_data_ea), .spr_rdata(spr_rdata), .spr_ack(spr_ack),
    .monitor_control_word(monitor_control_word), .event_counter_two(event_counter_two),
    .perf_monitor_irq(perf_monitor_irq), .irq_take(irq_take));

  // --------------------
  // Tasks
  // --------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access; the ack stands only in the cycle after the taking edge
  task automatic spr(input logic wr, input logic [9:0] num, input logic [31:0] d);
    @(negedge mclk);
    spr_wr = wr;
    spr_rd = !wr;
    spr_num = num;
    spr_wdata = d;
    @(negedge mclk);
    spr_wr = 0;
    spr_rd = 0;
    q = spr_rdata;
    chk("ack", {31'h0, spr_ack}, {31'h0, !wr && supervisor});
  endtask
  task automatic drive_ev(input logic [5:0] c, input logic [2:0] v);
    {load_miss_pending, dcache_fill, itlb_miss, reserve_obtained, mfspr_dispatched, icbi_seen} = '0;
    {flush_op, bu_result, siu_result, ciu_result, bu_dispatch, siu_dispatch, ciu_dispatch, snoop_hit} = '0;
    {completed_count, dispatched_count, loads_completed, branch_completed_code} = '0;
    case (c)
      6'h02: completed_count = v;
      6'h04: dispatched_count = v;
      6'h05: load_miss_pending = v[0];
      6'h06: dcache_fill = v[0];
      6'h07: itlb_miss = v[0];
      6'h08: branch_completed_code = v[1:0];
      6'h09: reserve_obtained = v[0];
      6'h0a: mfspr_dispatched = v[0];
      6'h0b: icbi_seen = v[0];
      6'h0c: flush_op = v[0];
      6'h0d: bu_result = v[0];
      6'h0e: siu_result = v[0];
      6'h0f: ciu_result = v[0];
      6'h10: bu_dispatch = v[0];
      6'h11: siu_dispatch = v[0];
      6'h13: ciu_dispatch = v[0];
      6'h12: loads_completed = v;
      6'h14: snoop_hit = v[0];
      default: ;
    endcase
  endtask
  // Preload, count six cycles with the event held, read back
  task automatic run_count(input logic [5:0] c, input int inc);
    spr(1, SPR_CTRL, {26'h0, c});
    spr(1, SPR_CNT2, 32'h0000_0010);
    @(negedge mclk);
    count_enable = 1;
    repeat (6) @(negedge mclk);
    count_enable = 0;
    spr(0, SPR_CNT2, 0);
    chk("counter two", q, 32'h0000_0010 + 6 * inc);
    chk("counter port", event_counter_two, 32'h0000_0010 + 6 * inc);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    repeat (8) @(negedge mclk);
    sys_rst = 0;
    spr(0, SPR_SAMP_INST, 0);
    chk("inst sample reset", q, SAMPLE_RESET);
    spr(0, SPR_CTRL, 0);
    chk("ctrl reset", q, CTRL_RESET);
    chk("ctrl port reset", monitor_control_word, CTRL_RESET);
    spr(1, SPR_SAMP_INST, 32'h1234_5678);
    spr(1, SPR_SAMP_OPER, 32'h9abc_def0);
    spr(0, SPR_SAMP_INST, 0);
    chk("inst sample rw", q, 32'h1234_5678);
    spr(0, SPR_SAMP_OPER, 0);
    chk("oper sample rw", q, 32'h9abc_def0);
    supervisor = 0;
    spr(1, SPR_SAMP_INST, 32'h0000_0000);
    spr(0, SPR_SAMP_INST, 0);
    supervisor = 1;
    spr(0, SPR_SAMP_INST, 0);
    chk("user write", q, 32'h1234_5678);
    spr(0, 10'h03b9, 0);
    chk("unmapped", q, 32'h0000_0000);
    $display("test access done");
    for (int i = 0; i < 23; i++) begin
      drive_ev(EVC[i], EVV[i]);
      run_count(EVC[i], EVI[i]);
    end
    drive_ev(0, 0);
    $display("test events done");
    for (int s = 0; s < 4; s++) begin
      timebase_bit_select = s[1:0];
      tap = TAPS[s];
      tb_run = 1;
      run_count(EV_TB_TRANS, 1);
      tb_run = 0;
    end
    $display("test timebase done");
    {threshold_inst_ea, threshold_data_ea, last_completed_ea} = {32'haaaa_0004, 32'hbbbb_0008, 32'hcccc_000c};
    current_data_ea = 32'hdddd_0010;
    threshold_event = 1;
    spr(1, SPR_CNT2, 32'h8000_0000);
    spr(1, SPR_CTRL, 32'h0400_0000);
    repeat (4) @(negedge mclk);
    chk("no irq w/o control", {31'h0, perf_monitor_irq}, 32'h0);
    cnt2_int_control = 1;
    repeat (3) @(negedge mclk);
    cnt2_int_control = 0;
    chk("irq pending", {31'h0, perf_monitor_irq}, 32'h1);
    repeat (4) @(negedge mclk);
    chk("masked take", {30'h0, perf_monitor_irq, irq_take}, 32'h2);
    spr(0, SPR_CTRL, 0);
    chk("enable cleared", q, 32'h0000_0000);
    chk("ctrl port cleared", monitor_control_word, 32'h0000_0000);
    spr(0, SPR_SAMP_INST, 0);
    chk("inst sample thresh", q, 32'haaaa_0004);
    spr(0, SPR_SAMP_OPER, 0);
    chk("oper sample thresh", q, 32'hbbbb_0008);
    ext_irq_enable = 1;
    for (int k = 0; k < 5 && irq_take !== 1'b1; k++) @(negedge mclk);
    chk("taken", {31'h0, irq_take}, 32'h1);
    @(negedge mclk);
    chk("pending cleared", {31'h0, perf_monitor_irq}, 32'h0);
    threshold_event = 0;
    cnt2_int_control = 1;
    spr(1, SPR_CTRL, 32'h0400_0000);
    repeat (3) @(negedge mclk);
    cnt2_int_control = 0;
    last_completed_ea = 32'h0;
    repeat (3) @(negedge mclk);
    spr(0, SPR_SAMP_INST, 0);
    chk("inst sample last done", q, 32'hcccc_000c);
    $display("test irq done");
    give_verdict;
  end
endmodule

// ### core/pcm_counter_two.sv
`timescale 1ns/1ps
module pcm_counter_two
  import pcm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Special register access
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic supervisor,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  // Counting qualifiers and interrupt controls
  input wire logic count_enable,
  input wire logic cnt2_int_control,
  input wire logic ext_irq_enable,
  // Event inputs from the core
  input wire logic [63:0] timebase,
  input wire logic [1:0] timebase_bit_select,
  input wire logic [2:0] completed_count,
  input wire logic [2:0] dispatched_count,
  input wire logic load_miss_pending,
  input wire logic dcache_fill,
  input wire logic itlb_miss,
  input wire logic [1:0] branch_completed_code,
  input wire logic reserve_obtained,
  input wire logic mfspr_dispatched,
  input wire logic icbi_seen,
  input wire logic flush_op,
  input wire logic bu_result,
  input wire logic siu_result,
  input wire logic ciu_result,
  input wire logic bu_dispatch,
  input wire logic siu_dispatch,
  input wire logic ciu_dispatch,
  input wire logic [2:0] loads_completed,
  input wire logic snoop_hit,
  // Sample sources
  input wire logic threshold_event,
  input wire logic [31:0] threshold_inst_ea,
  input wire logic [31:0] threshold_data_ea,
  input wire logic [31:0] last_completed_ea,
  input wire logic [31:0] current_data_ea,
  // Results
  output logic [31:0] spr_rdata,
  output logic spr_ack,
  output logic [31:0] monitor_control_word,
  output logic [31:0] event_counter_two,
  output logic perf_monitor_irq,
  output logic irq_take
);
  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  // Clamp a 0..4 count; illegal codes above four add nothing
  function automatic logic [2:0] clamp_four(input logic [2:0] v);
    clamp_four = (v > MAX_FOUR) ? 3'h0 : v;
  endfunction

  logic [31:0] sampled_instruction_address;
  logic [31:0] sampled_operand_address;
  logic tb_prev;
  logic tb_bit;
  logic [2:0] incr;
  logic irq_fire;
  logic [31:0] next_ctrl;
  logic [31:0] next_cnt;
  logic next_pending;
  logic next_take;
  logic next_tb_prev;
  logic [31:0] next_rdata;
  logic next_ack;
  logic [5:0] sel2;

  assign sel2 = monitor_control_word[SEL2_MSB:SEL2_LSB];

  // Timebase tap picked by the select setting
  always_comb begin
    unique case (timebase_bit_select)
      2'd0: tb_bit = timebase[TB_BIT0];
      2'd1: tb_bit = timebase[TB_BIT1];
      2'd2: tb_bit = timebase[TB_BIT2];
      2'd3: tb_bit = timebase[TB_BIT3];
    endcase
  end

  // Per-cycle occurrence count; unknown codes count nothing
  always_comb begin
    incr = 3'h0;
    case (sel2)
      EV_NONE: incr = 3'h0;
      EV_CYCLES: incr = 3'h1;
      EV_COMPLETED: incr = clamp_four(completed_count);
      EV_TB_TRANS: incr = {2'b00, tb_bit ^ tb_prev};
      EV_DISPATCHED: incr = clamp_four(dispatched_count);
      EV_LOAD_MISS_CYC: incr = {2'b00, load_miss_pending};
      EV_DCACHE_FILL: incr = {2'b00, dcache_fill};
      EV_ITLB_MISS: incr = {2'b00, itlb_miss};
      // Code 01 is never produced, so it adds nothing
      EV_BRANCHES: incr = branch_completed_code[1] ? {2'b00, 1'b1} + {2'b00, branch_completed_code[0]} : 3'h0;
      EV_RESERVE: incr = {2'b00, reserve_obtained};
      EV_MFSPR: incr = {2'b00, mfspr_dispatched};
      EV_ICBI: incr = {2'b00, icbi_seen};
      EV_FLUSH: incr = {2'b00, flush_op};
      EV_BU_RESULT: incr = {2'b00, bu_result};
      EV_SIU_RESULT: incr = {2'b00, siu_result};
      EV_CIU_RESULT: incr = {2'b00, ciu_result};
      EV_BU_DISP: incr = {2'b00, bu_dispatch};
      EV_SIU_DISP: incr = {2'b00, siu_dispatch};
      EV_CIU_DISP: incr = {2'b00, ciu_dispatch};
      EV_LOADS: incr = clamp_four(loads_completed);
      EV_SNOOP_HIT: incr = {2'b00, snoop_hit};
      default: incr = 3'h0;
    endcase
  end

  // ----------------------------------------
  // Interrupt signalling
  // ----------------------------------------
  assign irq_fire = cnt2_int_control & event_counter_two[31] & monitor_control_word[CTRL_SIGEN_POS];

  // Next values of control, counter, pending and read port
  always_comb begin
    next_ctrl = monitor_control_word;
    next_cnt = event_counter_two;
    next_pending = perf_monitor_irq;
    next_rdata = spr_rdata;
    next_ack = 1'b0;
    next_tb_prev = tb_bit;
    if (spr_wr && supervisor && spr_num == SPR_CTRL) next_ctrl = spr_wdata;
    // Hardware clear wins over a software write in the same cycle
    if (irq_fire) next_ctrl[CTRL_SIGEN_POS] = 1'b0;
    if (spr_wr && supervisor && spr_num == SPR_CNT2) begin
      next_cnt = spr_wdata;
    end else if (count_enable) begin
      next_cnt = event_counter_two + {29'h0, incr};
    end
    if (irq_fire) next_pending = 1'b1;
    else if (irq_take) next_pending = 1'b0;
    // Pending stays until the external enable lets it be taken
    next_take = perf_monitor_irq & ext_irq_enable & ~irq_take;
    if (spr_rd && supervisor) begin
      next_ack = 1'b1;
      unique case (spr_num)
        SPR_CTRL: next_rdata = monitor_control_word;
        SPR_CNT2: next_rdata = event_counter_two;
        SPR_SAMP_INST: next_rdata = sampled_instruction_address;
        SPR_SAMP_OPER: next_rdata = sampled_operand_address;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      monitor_control_word <= CTRL_RESET;
      event_counter_two <= CNT_RESET;
      perf_monitor_irq <= 1'b0;
      irq_take <= 1'b0;
      tb_prev <= 1'b0;
      spr_rdata <= 32'h0000_0000;
      spr_ack <= 1'b0;
    end else begin
      monitor_control_word <= next_ctrl;
      event_counter_two <= next_cnt;
      perf_monitor_irq <= next_pending;
      irq_take <= next_take;
      tb_prev <= next_tb_prev;
      spr_rdata <= next_rdata;
      spr_ack <= next_ack;
    end
  end

  // ----------------------------------------
  // Sample registers
  // ----------------------------------------
  pcm_sample_regs u_samples (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .capture(irq_fire),
    .cap_inst(threshold_event ? threshold_inst_ea : last_completed_ea),
    .cap_data(threshold_event ? threshold_data_ea : current_data_ea),
    .wr_inst(spr_wr && supervisor && spr_num == SPR_SAMP_INST),
    .wr_oper(spr_wr && supervisor && spr_num == SPR_SAMP_OPER),
    .wr_data(spr_wdata),
    .sampled_instruction_address(sampled_instruction_address),
    .sampled_operand_address(sampled_operand_address)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_hold_none: assert property (@(posedge mclk) disable iff (sys_rst)
    (sel2 == EV_NONE && !spr_wr) |=> $stable(event_counter_two))
    else $error("counter moved with no event selected");
  chk_cycle_count: assert property (@(posedge mclk) disable iff (sys_rst)
    (sel2 == EV_CYCLES && count_enable && !spr_wr) |=> event_counter_two == $past(event_counter_two) + 32'h1)
    else $error("cycle count did not advance by one");
  chk_sigen_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_fire |=> !monitor_control_word[CTRL_SIGEN_POS])
    else $error("signal enable not cleared");
  chk_irq_pending: assert property (@(posedge mclk) disable iff (sys_rst)
    irq_fire |=> perf_monitor_irq)
    else $error("irq not pending after signal");
  chk_masked_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (perf_monitor_irq && !ext_irq_enable && !irq_take) |=> !irq_take && perf_monitor_irq)
    else $error("masked irq taken or lost");
  chk_sample_inst: assert property (@(posedge mclk) disable iff (sys_rst)
    (irq_fire && threshold_event) |=> sampled_instruction_address == $past(threshold_inst_ea))
    else $error("threshold instruction address not sampled");
  chk_sample_last: assert property (@(posedge mclk) disable iff (sys_rst)
    (irq_fire && !threshold_event) |=> sampled_instruction_address == $past(last_completed_ea))
    else $error("last completed address not sampled");
  chk_sample_data: assert property (@(posedge mclk) disable iff (sys_rst)
    (irq_fire && threshold_event) |=> sampled_operand_address == $past(threshold_data_ea))
    else $error("operand address not sampled");
  chk_branch_two: assert property (@(posedge mclk) disable iff (sys_rst)
    (sel2 == EV_BRANCHES && count_enable && !spr_wr && branch_completed_code == 2'b11)
    |=> event_counter_two == $past(event_counter_two) + 32'h2)
    else $error("two branches not added");
endmodule

// ### core/pcm_pkg.sv
// What this block does
// - Counter two event from control bits 26-31
// - Code zero holds counter value
// - Cycles and dispatched instructions counted
// - Completed instructions add zero to four
// - Timebase bit transitions, selectable bit
// - Cycles with load miss outstanding
// - Data cache fills and itlb misses
// - Branches completed, two-bit coded increment
// - Reservations obtained, mfspr dispatched counted
// - icbi counted regardless of hit
// - Pipeline flushing operations counted
// - Branch, simple, complex unit results
// - Dispatches to branch, simple, complex units
// - Completed loads add zero to four
// - Snoop hits counted
// - Threshold irq samples exact instruction
// - Other irq samples last completed instruction
// - Threshold irq samples operand address
// - Sample registers supervisor SPR 955, 959
// - Samples held after irq for software
// - Irq pending until external enable set
// - Signal enable cleared when irq signalled
// - Irq on control, counter msb, enable
package pcm_pkg;
  // ----------------------------------------
  // Special register numbers
  // ----------------------------------------
  localparam logic [9:0] SPR_CTRL = 10'h03b8;
  localparam logic [9:0] SPR_CNT2 = 10'h03ba;
  localparam logic [9:0] SPR_SAMP_INST = 10'h03bb;
  localparam logic [9:0] SPR_SAMP_OPER = 10'h03bf;
  // ----------------------------------------
  // Control word fields (bit 0 is the msb)
  // ----------------------------------------
  localparam int CTRL_SIGEN_POS = 31 - 5;
  localparam int SEL2_LSB = 31 - 31;
  localparam int SEL2_MSB = 31 - 26;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SAMPLE_RESET = 32'h0000_0000;
  // ----------------------------------------
  // Timebase bit positions (lsb-0 of 64-bit timebase)
  // ----------------------------------------
  localparam int TB_BIT0 = 63 - 47;
  localparam int TB_BIT1 = 63 - 51;
  localparam int TB_BIT2 = 63 - 55;
  localparam int TB_BIT3 = 63 - 63;
  // ----------------------------------------
  // Event select codes for counter two
  // ----------------------------------------
  typedef enum logic [5:0] {
    EV_NONE = 6'h00, EV_CYCLES = 6'h01, EV_COMPLETED = 6'h02, EV_TB_TRANS = 6'h03,
    EV_DISPATCHED = 6'h04, EV_LOAD_MISS_CYC = 6'h05, EV_DCACHE_FILL = 6'h06, EV_ITLB_MISS = 6'h07,
    EV_BRANCHES = 6'h08, EV_RESERVE = 6'h09, EV_MFSPR = 6'h0a, EV_ICBI = 6'h0b,
    EV_FLUSH = 6'h0c, EV_BU_RESULT = 6'h0d, EV_SIU_RESULT = 6'h0e, EV_CIU_RESULT = 6'h0f,
    EV_BU_DISP = 6'h10, EV_SIU_DISP = 6'h11, EV_LOADS = 6'h12, EV_CIU_DISP = 6'h13,
    EV_SNOOP_HIT = 6'h14
  } pcm_event_type;
  localparam logic [2:0] MAX_FOUR = 3'h4;
endpackage

// ### core/pcm_sample_regs.sv
`timescale 1ns/1ps
module pcm_sample_regs
  import pcm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Capture from irq signalling
  input wire logic capture,
  input wire logic [31:0] cap_inst,
  input wire logic [31:0] cap_data,
  // Software write
  input wire logic wr_inst,
  input wire logic wr_oper,
  input wire logic [31:0] wr_data,
  // Held samples
  output logic [31:0] sampled_instruction_address,
  output logic [31:0] sampled_operand_address
);
  logic [31:0] next_inst_sample;
  logic [31:0] next_oper_sample;

  // Capture beats a software write in the same cycle, so the sample stays meaningful
  always_comb begin
    next_inst_sample = sampled_instruction_address;
    next_oper_sample = sampled_operand_address;
    if (capture) begin
      next_inst_sample = cap_inst;
      next_oper_sample = cap_data;
    end else begin
      if (wr_inst) next_inst_sample = wr_data;
      if (wr_oper) next_oper_sample = wr_data;
    end
  end

  // Values stay until the next signalled irq or software write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sampled_instruction_address <= SAMPLE_RESET;
      sampled_operand_address <= SAMPLE_RESET;
    end else begin
      sampled_instruction_address <= next_inst_sample;
      sampled_operand_address <= next_oper_sample;
    end
  end
endmodule
